//--- rtl/ctt_irq_pin.sv
// Purpose: External interrupt handling: falling-edge NMI and two-way pin
// Assumes: Inputs synchronous to CLOCK
// Notes: Mirror changes only on first-state strobe; pin also changes when the ack delay ends
`timescale 1ns/1ps
`default_nettype none
module ctt_irq_pin (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic t1_start,
  input wire logic nmi_pin_n,
  input wire logic nmi_ack,
  input wire logic dir_bit,
  input wire logic mask_wr,
  input wire logic mask_wdata,
  input wire logic remote_status_wr,
  input wire logic pin_in,
  output logic nmi_pending,
  output logic mask_bit,
  output logic pin_out,
  output logic pin_oe,
  output logic mirror_bit,
  output logic level_irq
);
  typedef struct packed {
    logic nmi_last;
    logic nmi_pend;
    logic mask;
    logic pin;
    logic mirror;
    logic [1:0] ack_cnt;
  } ctt_irq_st_t;
  ctt_irq_st_t s, next_s;
  always_comb begin
    next_s = s;
    next_s.nmi_last = nmi_pin_n;
    // Edge wins over the clear so a new edge is never lost
    if (nmi_ack)
      next_s.nmi_pend = 1'b0;
    if (s.nmi_last && !nmi_pin_n)
      next_s.nmi_pend = 1'b1;
    if (remote_status_wr && dir_bit) begin
      next_s.mask = ~s.mask;
      next_s.ack_cnt = ctt_pkg::ACK_DELAY;
    end
    // CPU write lands after the toggle and so takes precedence
    if (mask_wr)
      next_s.mask = mask_wdata;
    if (s.ack_cnt != 2'h0) begin
      next_s.ack_cnt = s.ack_cnt - 2'h1;
      if (s.ack_cnt == 2'h1 && dir_bit)
        next_s.pin = s.mask;
    end
    if (t1_start) begin
      if (dir_bit)
        next_s.pin = s.mask;
      next_s.mirror = dir_bit ? s.pin : pin_in;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '{nmi_last: 1'b1, nmi_pend: 1'b0, mask: ctt_pkg::MASK_RESET,
             pin: 1'b1, mirror: 1'b1, ack_cnt: 2'h0};
    end else if (ce) begin
      s <= next_s;
    end
  end
  assign nmi_pending = s.nmi_pend;
  assign mask_bit = s.mask;
  assign pin_out = s.pin;
  assign pin_oe = dir_bit;
  assign mirror_bit = s.mirror;
  assign level_irq = !dir_bit && !pin_in;
  nmi_edge_a: assert property (@(posedge clk) disable iff (rst)
    ce && s.nmi_last && !nmi_pin_n |=> s.nmi_pend)
    else $error("nmi edge not latched");
  in_mode_a: assert property (@(posedge clk) disable iff (rst)
    ce && remote_status_wr && !dir_bit && !mask_wr |=> $stable(s.mask))
    else $error("remote ack changed mask in input mode");
  cpu_wins_a: assert property (@(posedge clk) disable iff (rst)
    ce && mask_wr |=> s.mask == $past(mask_wdata))
    else $error("cpu mask value lost");
endmodule
`default_nettype wire

//--- rtl/ctt_pkg.sv
// Purpose: Constants for the CPU timing sequencer and external interrupts
// Assumes: One CPU clock, synchronous active-high reset
// Notes: Wait counts are loaded from plain ports
package ctt_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned IW_W = 2;
  localparam int unsigned DW_W = 3;
  localparam logic [1:0] IW_RESET = 2'h3;
  localparam logic [2:0] DW_RESET = 3'h7;
  localparam logic [1:0] KICK_IW = 2'h3;
  localparam logic [15:0] KICK_PC = 16'h0000;
  localparam int unsigned PC_W = 16;
  localparam logic MASK_RESET = 1'b1;
  localparam logic DIR_RESET = 1'b0;
  localparam logic [1:0] ACK_DELAY = 2'h2;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_START = 7'h02,
    ST_FIRST = 7'h04,
    ST_MID   = 7'h08,
    ST_WAIT  = 7'h10,
    ST_FINAL = 7'h20,
    ST_HOLD  = 7'h40
  } ctt_state_t;
endpackage

//--- rtl/ctt_timing.sv
// Purpose: Instruction timing sequencer with stall, run control, kick-start
// Assumes: WAIT_N, LOCK_N and arbiter inputs synchronous to CLOCK
// Notes: Falling-edge actions are registered one half state early in spirit
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Stall while stall input sampled low
// - Stall behaves exactly like programmed waits
// - Stopped after reset; run bit controls execution
// - Strap levels at reset release cause kick-start
// - Boundary clock rises on the second clock after release
// - Dummy fetch: three waits then final
// - Idle after reset, change on rising edges
// - First state raises boundary clock, loads counter
// - Data access requests bus, raises latch strobe
// - Intermediate loads data count, drops strobe
// - Write strobe low in wait and final
// - End of instruction: stop if run low
// - Falling edge NMI, self-clearing on recognition
// - Direction bit selects pin direction, resets zero
// - Mirror bit follows pin at first state
// - Input mode low pin is level request
// - Output pin follows mask at first state
// - Remote status write toggles mask in output
// - Remote status write ignored in input mode
// - CPU mask write wins over remote toggle
// - Mask bits reset to one
module ctt_timing #(
  parameter int unsigned PC_W = ctt_pkg::PC_W
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  input wire logic REMOTE_WRITE_STROBE_N,
  input wire logic REMOTE_READ_STROBE_N,
  input wire logic REMOTE_ACCESS_ENABLE,
  input wire logic RUN_BIT_WR,
  input wire logic RUN_BIT_WDATA,
  input wire logic WAIT_N,
  input wire logic LOCK_N,
  input wire logic ARB_BUSY,
  input wire logic DATA_ACCESS,
  input wire logic DATA_WRITE,
  input wire logic [1:0] INSTR_WAITS,
  input wire logic [2:0] DATA_WAITS,
  input wire logic NMI_N,
  input wire logic NMI_ACK,
  input wire logic IRQ_PIN_DIR_BIT,
  input wire logic MASK_WR,
  input wire logic MASK_WDATA,
  input wire logic REMOTE_STATUS_WR,
  input wire logic BIDIR_IRQ_PIN_IN,
  output logic INSTR_BOUNDARY_CLOCK,
  output logic ADDR_LATCH,
  output logic BUS_REQUEST,
  output logic WRITE_N,
  output logic RUN_BIT,
  output logic RUNNING,
  output logic PC_RESTART,
  output logic [PC_W-1:0] PC_LOAD_VALUE,
  output logic NMI_PENDING,
  output logic BIDIR_IRQ_MASK_BIT,
  output logic BIDIR_IRQ_STATUS_BIT,
  output logic BIDIR_IRQ_PIN_OUT,
  output logic BIDIR_IRQ_PIN_OE,
  output logic BIDIR_IRQ_MIRROR,
  output logic BIDIR_IRQ_REQUEST
);
  typedef struct packed {
    ctt_pkg::ctt_state_t st;
    logic in_reset;
    logic kick;
    logic run;
    logic instr_boundary_clock;
    logic ale;
    logic breq;
    logic wr_n;
    logic is_data;
    logic is_write;
    logic [1:0] iw;
    logic [2:0] dw;
    logic t1_pulse;
    logic pc_restart;
    logic dir;
    logic irq_req;
  } ctt_st_t;
  ctt_st_t s, next_s;
  logic nmi_pend, mask_b, pin_o, pin_e, mirror_b, lvl_irq;
  logic waits_done;
  // Pin stall looks like one more wait state, evaluated at the same point
  assign waits_done = (s.iw == 2'h0) && (s.dw == 3'h0) && WAIT_N;
  always_comb begin
    next_s = s;
    next_s.t1_pulse = 1'b0;
    next_s.pc_restart = 1'b0;
    next_s.in_reset = 1'b0;
    next_s.dir = IRQ_PIN_DIR_BIT;
    next_s.irq_req = lvl_irq;
    if (RUN_BIT_WR)
      next_s.run = RUN_BIT_WDATA;
    // Strap seen on the first clock after release, never under reset
    if (s.in_reset && !REMOTE_WRITE_STROBE_N && !REMOTE_READ_STROBE_N &&
        REMOTE_ACCESS_ENABLE) begin
      next_s.kick = 1'b1;
      next_s.run = 1'b1;
    end
    unique case (s.st)
      ctt_pkg::ST_IDLE: begin
        if (next_s.kick) begin
          next_s.st = ctt_pkg::ST_START;
          next_s.pc_restart = 1'b1;
        end else if (s.run) begin
          next_s.st = ctt_pkg::ST_FIRST;
          next_s.instr_boundary_clock = 1'b1;
          next_s.iw = INSTR_WAITS;
          next_s.t1_pulse = 1'b1;
          next_s.is_data = DATA_ACCESS;
          next_s.is_write = DATA_WRITE;
          next_s.breq = DATA_ACCESS;
        end
      end
      ctt_pkg::ST_START: begin
        // Dummy fetch: boundary clock up, then three waits and final
        next_s.st = ctt_pkg::ST_HOLD;
        next_s.instr_boundary_clock = 1'b1;
        next_s.iw = ctt_pkg::KICK_IW;
        next_s.dw = 3'h0;
        next_s.is_data = 1'b0;
        next_s.kick = 1'b0;
      end
      ctt_pkg::ST_HOLD: begin
        next_s.instr_boundary_clock = 1'b0;
        next_s.st = ctt_pkg::ST_WAIT;
        next_s.iw = s.iw - 2'h1;
      end
      ctt_pkg::ST_FIRST: begin
        next_s.ale = s.is_data;
        // Data waits count only in data accesses; clear any reset leftover
        if (!s.is_data)
          next_s.dw = 3'h0;
        if (s.is_data) begin
          if (LOCK_N && !ARB_BUSY) begin
            next_s.st = ctt_pkg::ST_MID;
            next_s.breq = 1'b0;
            next_s.instr_boundary_clock = 1'b0;
          end
        end else if (s.iw != 2'h0 || !WAIT_N) begin
          next_s.st = ctt_pkg::ST_WAIT;
          next_s.instr_boundary_clock = 1'b0;
          if (s.iw != 2'h0)
            next_s.iw = s.iw - 2'h1;
        end else begin
          next_s.st = ctt_pkg::ST_FINAL;
          next_s.instr_boundary_clock = 1'b0;
        end
      end
      ctt_pkg::ST_MID: begin
        next_s.ale = 1'b0;
        next_s.dw = DATA_WAITS;
        if (s.iw != 2'h0)
          next_s.iw = s.iw - 2'h1;
        if (DATA_WAITS != 3'h0 || (s.iw > 2'h1) || !WAIT_N) begin
          next_s.st = ctt_pkg::ST_WAIT;
          next_s.wr_n = !s.is_write;
          if (DATA_WAITS != 3'h0)
            next_s.dw = DATA_WAITS - 3'h1;
          if (s.iw > 2'h1)
            next_s.iw = s.iw - 2'h2;
          else
            next_s.iw = 2'h0;
        end else begin
          next_s.st = ctt_pkg::ST_FINAL;
          next_s.wr_n = !s.is_write;
        end
      end
      ctt_pkg::ST_WAIT: begin
        if (waits_done) begin
          next_s.st = ctt_pkg::ST_FINAL;
        end else begin
          if (s.iw != 2'h0)
            next_s.iw = s.iw - 2'h1;
          if (s.dw != 3'h0)
            next_s.dw = s.dw - 3'h1;
        end
      end
      ctt_pkg::ST_FINAL: begin
        next_s.wr_n = 1'b1;
        if (next_s.run) begin
          next_s.st = ctt_pkg::ST_FIRST;
          next_s.instr_boundary_clock = 1'b1;
          next_s.iw = INSTR_WAITS;
          next_s.t1_pulse = 1'b1;
          next_s.is_data = DATA_ACCESS;
          next_s.is_write = DATA_WRITE;
          next_s.breq = DATA_ACCESS;
        end else begin
          next_s.st = ctt_pkg::ST_IDLE;
        end
      end
      default: next_s.st = ctt_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      s <= '{st: ctt_pkg::ST_IDLE, in_reset: 1'b1, kick: 1'b0, run: 1'b0,
             instr_boundary_clock: 1'b0, ale: 1'b0, breq: 1'b0, wr_n: 1'b1,
             is_data: 1'b0, is_write: 1'b0, iw: ctt_pkg::IW_RESET,
             dw: ctt_pkg::DW_RESET, t1_pulse: 1'b0, pc_restart: 1'b0,
             dir: ctt_pkg::DIR_RESET, irq_req: 1'b0};
    end else if (CE) begin
      s <= next_s;
    end
  end
  ctt_irq_pin u_irq (
    .clk(CLOCK),
    .rst(RST),
    .ce(CE),
    .t1_start(next_s.t1_pulse),
    .nmi_pin_n(NMI_N),
    .nmi_ack(NMI_ACK),
    .dir_bit(IRQ_PIN_DIR_BIT),
    .mask_wr(MASK_WR),
    .mask_wdata(MASK_WDATA),
    .remote_status_wr(REMOTE_STATUS_WR),
    .pin_in(BIDIR_IRQ_PIN_IN),
    .nmi_pending(nmi_pend),
    .mask_bit(mask_b),
    .pin_out(pin_o),
    .pin_oe(pin_e),
    .mirror_bit(mirror_b),
    .level_irq(lvl_irq)
  );
  // Pin-side outputs are flops inside the submodule or flopped dir and request copies here
  assign INSTR_BOUNDARY_CLOCK = s.instr_boundary_clock;
  assign ADDR_LATCH = s.ale;
  assign BUS_REQUEST = s.breq;
  assign WRITE_N = s.wr_n;
  assign RUN_BIT = s.run;
  assign RUNNING = (s.st != ctt_pkg::ST_IDLE);
  assign PC_RESTART = s.pc_restart;
  assign PC_LOAD_VALUE = PC_W'(ctt_pkg::KICK_PC);
  assign NMI_PENDING = nmi_pend;
  assign BIDIR_IRQ_MASK_BIT = mask_b;
  assign BIDIR_IRQ_STATUS_BIT = mask_b;
  assign BIDIR_IRQ_PIN_OUT = pin_o;
  assign BIDIR_IRQ_PIN_OE = s.dir;
  assign BIDIR_IRQ_MIRROR = mirror_b;
  assign BIDIR_IRQ_REQUEST = s.irq_req;
  sequence final_seen;
    s.st == ctt_pkg::ST_FINAL;
  endsequence
  stall_hold_a: assert property (@(posedge CLOCK) disable iff (RST)
    CE && s.st == ctt_pkg::ST_WAIT && !WAIT_N |=> s.st != ctt_pkg::ST_FINAL)
    else $error("final entered while stalled");
  idle_stop_a: assert property (@(posedge CLOCK) disable iff (RST)
    (final_seen and (CE && !next_s.run)) |=> s.st == ctt_pkg::ST_IDLE)
    else $error("did not stop at end");
  kick_instr_boundary_clock_a: assert property (@(posedge CLOCK) disable iff (RST)
    CE && s.st == ctt_pkg::ST_START |=> s.instr_boundary_clock)
    else $error("boundary clock missing on kick");
  first_instr_boundary_clock_a: assert property (@(posedge CLOCK) disable iff (RST)
    s.st == ctt_pkg::ST_FIRST |-> s.instr_boundary_clock)
    else $error("boundary clock low in first state");
  lock_wait_a: assert property (@(posedge CLOCK) disable iff (RST)
    CE && s.st == ctt_pkg::ST_FIRST && s.is_data && !LOCK_N
    |=> s.st == ctt_pkg::ST_FIRST)
    else $error("data access ran under lock");
  ale_drop_a: assert property (@(posedge CLOCK) disable iff (RST)
    CE && s.st == ctt_pkg::ST_MID |=> !s.ale)
    else $error("latch strobe not dropped");
  wr_low_a: assert property (@(posedge CLOCK) disable iff (RST)
    s.st == ctt_pkg::ST_FINAL && s.is_write && s.is_data |-> !s.wr_n)
    else $error("write strobe high in final");
  idle_start_a: assert property (@(posedge CLOCK) disable iff (RST)
    CE && s.st == ctt_pkg::ST_IDLE && !s.run && !next_s.kick
    |=> s.st == ctt_pkg::ST_IDLE)
    else $error("left idle without run");
endmodule
`default_nettype wire

//--- testbench/cpu_timing_ctrl_ext_irq_bench.sv
// Purpose: Self-checking bench for the timing sequencer and external irqs
// Assumes: CE held high; the partner model drives stall and pin level
// Notes: Instruction length is taken between boundary clock rises
`timescale 1ns/1ps
`default_nettype none
module cpu_timing_ctrl_ext_irq_bench;
  logic clk = 1'b0, rst = 1'b1, rws_n = 1'b1, rrs_n = 1'b1, remote_access_enable = 1'b0;
  logic run_wr = 1'b0, run_wd = 1'b0, lock_n = 1'b1, arb = 1'b0;
  logic da = 1'b0, dwr = 1'b0, nmi_n = 1'b1, nmi_ack = 1'b0, dir = 1'b0;
  logic mask_wr = 1'b0, mask_wd = 1'b0, rsw = 1'b0, hold_low = 1'b0;
  logic [1:0] iw = 2'h0;
  logic [2:0] dw = 3'h0;
  logic [5:0] stall = 6'h0;
  logic wait_n, pin_in, instr_boundary_clock, ale, breq, write_n, run_bit, running;
  logic pc_restart, nmi_p, mask, status, pin_out, pin_oe, mirror, req;
  logic [15:0] pc_val;
  logic instr_boundary_clock_q = 1'b0, kicked = 1'b0;
  int cyc = 0, last = 0, rises = 0, rel = 0, miscompares = 0, cmp_count = 0;
  logic [15:0] exp_q[$];
  ctt_timing i_dut (
    .CLOCK(clk), .RST(rst), .CE(1'b1),
    .REMOTE_WRITE_STROBE_N(rws_n), .REMOTE_READ_STROBE_N(rrs_n),
    .REMOTE_ACCESS_ENABLE(remote_access_enable), .RUN_BIT_WR(run_wr),
    .RUN_BIT_WDATA(run_wd), .WAIT_N(wait_n), .LOCK_N(lock_n),
    .ARB_BUSY(arb), .DATA_ACCESS(da), .DATA_WRITE(dwr),
    .INSTR_WAITS(iw), .DATA_WAITS(dw), .NMI_N(nmi_n), .NMI_ACK(nmi_ack),
    .IRQ_PIN_DIR_BIT(dir), .MASK_WR(mask_wr), .MASK_WDATA(mask_wd),
    .REMOTE_STATUS_WR(rsw), .BIDIR_IRQ_PIN_IN(pin_in),
    .INSTR_BOUNDARY_CLOCK(instr_boundary_clock), .ADDR_LATCH(ale), .BUS_REQUEST(breq),
    .WRITE_N(write_n), .RUN_BIT(run_bit), .RUNNING(running),
    .PC_RESTART(pc_restart), .PC_LOAD_VALUE(pc_val),
    .NMI_PENDING(nmi_p), .BIDIR_IRQ_MASK_BIT(mask),
    .BIDIR_IRQ_STATUS_BIT(status), .BIDIR_IRQ_PIN_OUT(pin_out),
    .BIDIR_IRQ_PIN_OE(pin_oe), .BIDIR_IRQ_MIRROR(mirror),
    .BIDIR_IRQ_REQUEST(req)
  );
  ctt_remote_model i_far (
    .clk(clk), .instr_boundary_clock(instr_boundary_clock), .stall_len(stall), .hold_low(hold_low),
    .pin_out(pin_out), .pin_oe(pin_oe), .wait_n(wait_n),
    .pin_level(pin_in)
  );
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic settle(input int n);
    step(n);
    #1;
  endtask
  // Waits at negedge plus a step so the monitor has counted the rise
  task automatic rise_wait(input int n);
    int r;
    r = rises + n;
    while (rises < r) begin
      @(negedge clk);
      #1;
    end
  endtask
  task automatic run_write(input logic v);
    @(posedge clk);
    run_wr <= 1'b1;
    run_wd <= v;
    @(posedge clk);
    run_wr <= 1'b0;
  endtask
  // Stalls are only used with one programmed wait, so they simply add
  task automatic measure(input logic a, input logic w, input int i,
                         input int d, input int h);
    int e, n, r;
    @(posedge clk);
    da <= a;
    dwr <= w;
    iw <= i[1:0];
    dw <= d[2:0];
    stall <= h[5:0];
    e = a ? 3 + ((d > i - 1) ? d : i - 1) : 2 + i + h;
    rise_wait(2);
    exp_q.push_back(16'(e));
    r = rises;
    n = 0;
    while (rises == r) begin
      @(negedge clk);
      #1;
      if (write_n === 1'b0)
        n++;
    end
    check(16'(n), 16'((a && w) ? e - 2 : 0));
  endtask
  always @(negedge clk) begin
    cyc++;
    if (pc_restart === 1'b1)
      kicked = 1'b1;
    if (instr_boundary_clock === 1'b1 && !instr_boundary_clock_q) begin
      if (exp_q.size() > 0)
        check(16'(cyc - last), exp_q.pop_front());
      last = cyc;
      rises++;
    end
    instr_boundary_clock_q = (instr_boundary_clock === 1'b1);
  end
  always @(posedge clk) begin
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(32'h2a1a7683));
    step(2);
    rst <= 1'b0;
    settle(10);
    check(16'(running), 16'h0);
    check(16'(mask), 16'h1);
    check(16'(pin_oe), 16'h0);
    run_write(1'b1);
    settle(1);
    check(16'(instr_boundary_clock), 16'h1);
    measure(1'b0, 1'b0, 0, 0, 0);
    measure(1'b0, 1'b0, 3, 0, 0);
    measure(1'b0, 1'b0, 2, 0, 0);
    measure(1'b0, 1'b0, 1, 0, 1);
    measure(1'b0, 1'b0, 1, 0, 30);
    measure(1'b1, 1'b1, 0, 1, 0);
    measure(1'b1, 1'b1, 2, 0, 0);
    measure(1'b1, 1'b0, 3, 7, 0);
    measure(1'b0, 1'b0, 1, 0, 1 + $urandom % 8);
    repeat (4) begin
      measure(1'b1, 1'($urandom), $urandom % 4, $urandom % 8, 0);
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      lock_n <= 1'(k);
      arb <= 1'(k);
      rise_wait(1);
      settle(8);
      check(16'(instr_boundary_clock), 16'h1);
      check(16'(breq), 16'h1);
      @(posedge clk);
      lock_n <= 1'b1;
      arb <= 1'b0;
    end
    measure(1'b0, 1'b0, 0, 0, 0);
    @(posedge clk) nmi_n <= 1'b0;
    settle(3);
    check(16'(nmi_p), 16'h1);
    @(posedge clk) nmi_ack <= 1'b1;
    @(posedge clk) nmi_ack <= 1'b0;
    @(posedge clk) nmi_n <= 1'b1;
    settle(3);
    check(16'(nmi_p), 16'h0);
    @(posedge clk) rsw <= 1'b1;
    @(posedge clk) rsw <= 1'b0;
    hold_low <= 1'b1;
    settle(3);
    check(16'(mask), 16'h1);
    check(16'(req), 16'h1);
    rise_wait(2);
    check(16'(mirror), 16'h0);
    @(posedge clk) hold_low <= 1'b0;
    settle(3);
    check(16'(req), 16'h0);
    @(posedge clk) dir <= 1'b1;
    settle(2);
    check(16'(pin_oe), 16'h1);
    @(posedge clk) mask_wr <= 1'b1;
    @(posedge clk) mask_wr <= 1'b0;
    rise_wait(2);
    check(16'(pin_out), 16'h0);
    rise_wait(1);
    check(16'(mirror), 16'h0);
    @(posedge clk) rsw <= 1'b1;
    @(posedge clk) rsw <= 1'b0;
    #1;
    check(16'({mask, status}), 16'h3);
    settle(3);
    check(16'(pin_out), 16'h1);
    @(posedge clk);
    rsw <= 1'b1;
    mask_wr <= 1'b1;
    mask_wd <= 1'b1;
    @(posedge clk);
    rsw <= 1'b0;
    mask_wr <= 1'b0;
    rise_wait(2);
    check(16'({mask, pin_out}), 16'h3);
    run_write(1'b0);
    settle(12);
    check(16'({running, run_bit}), 16'h0);
    @(posedge clk);
    rst <= 1'b1;
    rws_n <= 1'b0;
    rrs_n <= 1'b0;
    remote_access_enable <= 1'b1;
    step(2);
    rst <= 1'b0;
    #1;
    rel = cyc;
    kicked = 1'b0;
    rise_wait(1);
    check(16'(last - rel), 16'h3);
    exp_q.push_back(16'h5);
    @(posedge clk);
    rws_n <= 1'b1;
    rrs_n <= 1'b1;
    remote_access_enable <= 1'b0;
    rise_wait(1);
    check(16'({kicked, running}), 16'h3);
    check(pc_val, 16'h0);
    give_verdict();
  end
endmodule
`default_nettype wire

//--- testbench/ctt_remote_model.sv
// Purpose: Remote host and external stall logic beside the sequencer
// Assumes: Runs on the CPU clock
// Notes: The interrupt pin floats high through its pull-up when undriven
`timescale 1ns/1ps
`default_nettype none
module ctt_remote_model (
  input wire logic clk,
  input wire logic instr_boundary_clock,
  input wire logic [5:0] stall_len,
  input wire logic hold_low,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic wait_n,
  output logic pin_level
);
  logic [5:0] left = 6'h0;
  // Stall is raised at the clock edge that ends the first state, well ahead of the final state
  always @(posedge clk) begin
    if (instr_boundary_clock && left == 6'h0 && stall_len != 6'h0)
      left <= stall_len;
    else if (left != 6'h0)
      left <= left - 6'h1;
  end
  assign wait_n = (left == 6'h0);
  // Remote keeps the pin low until the bench lets go
  assign pin_level = pin_oe ? pin_out : !hold_low;
endmodule
`default_nettype wire
